// [spl_top.sv]
// supply-driven output state, programming-mode entry and register locks
// assumes supply comparator levels arrive synchronous to clock_i; rstn_i is the
// power-on reset that the supply comparators produce
`timescale 1ns/1ps
`default_nettype none
`include "spl_regs.svh"

module spl_top
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic above_upper_reset_threshold_i,
   input wire logic below_lower_reset_threshold_i,
   input wire logic above_over_voltage_enable_level_i,
   input wire logic below_over_voltage_disable_level_i,
   input wire logic below_under_voltage_enable_level_i,
   input wire logic above_under_voltage_disable_level_i,
   input wire logic under_voltage_variant_i,
   input wire logic supply_above_program_enable_high_level_i,
   input wire logic program_enable_pin_i,
   input wire logic serial_drive_select_i,
   input wire logic output_disable_i,
   input wire logic serial_tx_bit_i,
   input wire logic access_valid_i,
   input wire logic access_write_i,
   input wire logic [5:0] access_addr_i,
   input wire logic [31:0] access_data_i,
   input wire logic permanent_lock_bit_i,
   output logic [1:0] pin_source_o,
   output logic sensor_output_pin_oe_o,
   output logic sensor_output_pin_o,
   output logic program_mode_o,
   output logic compensated_valid_o,
   output logic access_granted_o,
   output logic access_refused_o,
   output logic default_lock_o,
   output logic permanent_lock_o
);
   import spl_pkg::*;

   localparam int RELEASE_CYC = `SPL_RELEASE_CYC;
   localparam int WINDOW_CYC = `SPL_UNLOCK_WINDOW_CYC;
   localparam int COMP_CYC = `SPL_POWER_ON_CYC + `SPL_SETTLE_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // supply state

   spl_state_t state_q;
   spl_state_t state_d;
   logic [15:0] rel_cnt_q;
   logic [17:0] win_cnt_q;
   logic [15:0] comp_cnt_q;
   logic running;
   logic rel_done;
   logic prog_req;
   logic prog_ok;

   function automatic logic [15:0] sat_inc16(input logic [15:0] v, input int lim);
      sat_inc16 = (32'(v) >= lim) ? v : v + 16'h0001;
   endfunction : sat_inc16

   assign rel_done = 32'(rel_cnt_q) >= RELEASE_CYC;
   assign running = (state_q != SPL_RESET) && (state_q != SPL_RELEASE);
   assign prog_req = supply_above_program_enable_high_level_i
                     | (under_voltage_variant_i & program_enable_pin_i);
   assign prog_ok = prog_req && state_q == SPL_OVER;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         SPL_RESET:
            if (above_upper_reset_threshold_i)
               state_d = SPL_RELEASE;
         SPL_RELEASE:
            if (!above_upper_reset_threshold_i)
               state_d = SPL_RESET;
            else if (rel_done)
               state_d = SPL_RUN;
         SPL_RUN:
            if (above_over_voltage_enable_level_i)
               state_d = SPL_OVER;
            else if (under_voltage_variant_i && below_under_voltage_enable_level_i)
               state_d = SPL_UNDER;
         SPL_OVER:
            if (below_over_voltage_disable_level_i && !prog_req)
               state_d = SPL_RUN;
         SPL_UNDER:
            if (above_under_voltage_disable_level_i)
               state_d = SPL_RUN;
         default:
            state_d = SPL_RESET;
      endcase
      if (below_lower_reset_threshold_i && running)
         state_d = SPL_RESET;
   end

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         state_q <= SPL_RESET;
         rel_cnt_q <= 16'h0000;
         comp_cnt_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         rel_cnt_q <= (state_q == SPL_RELEASE) ? sat_inc16(rel_cnt_q, RELEASE_CYC) : 16'h0000;
         comp_cnt_q <= running ? sat_inc16(comp_cnt_q, COMP_CYC) : 16'h0000;
      end
   end

   // shadow counters kept apart from the design's own, so the timing checks do not copy its arithmetic
   logic [15:0] chk_rel_q;
   logic [15:0] chk_up_q;

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i || state_q != SPL_RELEASE)
         chk_rel_q <= 16'h0000;
      else
         chk_rel_q <= chk_rel_q + 16'h0001;
      if (!rstn_i || !running)
         chk_up_q <= 16'h0000;
      else if (32'(chk_up_q) < COMP_CYC)
         chk_up_q <= chk_up_q + 16'h0001;
   end

   chk_release_time: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_RELEASE && state_d == SPL_RUN |-> 32'(chk_rel_q) >= RELEASE_CYC)
      else $error("release time cut short");
   chk_release_wait: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(state_q == SPL_RELEASE) |-> ##1 (state_q != SPL_RUN) [*2])
      else $error("released early");
   chk_power_down: assert property (@(posedge clock_i) disable iff (!rstn_i)
      running && below_lower_reset_threshold_i |=> state_q == SPL_RESET ##1 !sensor_output_pin_oe_o)
      else $error("power-down missed");
   chk_comp_valid: assert property (@(posedge clock_i) disable iff (!rstn_i)
      compensated_valid_o |-> $past(running) && 32'(chk_up_q) >= COMP_CYC)
      else $error("compensated valid too early");

   ////////////////////////////////////////////////////////////////////////////
   // output pin source

   spl_pin_src_t src_d;
   assign src_d = !running ? SPL_PIN_HIZ :
                  (prog_req && serial_drive_select_i) ? SPL_PIN_SERIAL :
                  prog_req ? SPL_PIN_HIZ :
                  state_q == SPL_OVER ? SPL_PIN_HIZ :
                  state_q == SPL_UNDER ? SPL_PIN_LOW :
                  serial_drive_select_i ? SPL_PIN_SERIAL :
                  output_disable_i ? SPL_PIN_HIZ : SPL_PIN_ANALOG;

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         pin_source_o <= SPL_PIN_HIZ;
         sensor_output_pin_oe_o <= 1'b0;
         sensor_output_pin_o <= 1'b0;
         program_mode_o <= 1'b0;
         compensated_valid_o <= 1'b0;
      end
      else
      begin
         pin_source_o <= src_d;
         sensor_output_pin_oe_o <= (src_d == SPL_PIN_SERIAL) || (src_d == SPL_PIN_LOW);
         sensor_output_pin_o <= (src_d == SPL_PIN_SERIAL) && serial_tx_bit_i;
         program_mode_o <= running && prog_req;
         compensated_valid_o <= running && 32'(comp_cnt_q) >= COMP_CYC;
      end
   end

   chk_hiz_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !running |=> !sensor_output_pin_oe_o)
      else $error("pin driven in reset");
   chk_overv_hiz: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_OVER && !(prog_req && serial_drive_select_i) |=> pin_source_o == SPL_PIN_HIZ)
      else $error("over-voltage did not float");
   chk_under_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_UNDER && !prog_req |=> pin_source_o == SPL_PIN_LOW && !sensor_output_pin_o)
      else $error("under-voltage not low");
   chk_serial_drive: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_RUN && serial_drive_select_i
      |=> sensor_output_pin_oe_o && sensor_output_pin_o == $past(serial_tx_bit_i))
      else $error("serial bit not on pin");
   chk_analog_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_RUN && !prog_req && !serial_drive_select_i && !output_disable_i
      |=> pin_source_o == SPL_PIN_ANALOG)
      else $error("analog source not chosen");
   chk_prog_float: assert property (@(posedge clock_i) disable iff (!rstn_i)
      running && prog_req && !serial_drive_select_i |=> !sensor_output_pin_oe_o)
      else $error("pin driven in program mode");
   chk_prog_mode: assert property (@(posedge clock_i) disable iff (!rstn_i)
      running && supply_above_program_enable_high_level_i |=> program_mode_o)
      else $error("program mode missed");
   chk_pin_variant: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !under_voltage_variant_i && !supply_above_program_enable_high_level_i |=> !program_mode_o)
      else $error("program pin honoured outside variant");

   ////////////////////////////////////////////////////////////////////////////
   // access locks; reset is the power cycle, so lock state restarts with it

   logic perm_q;
   logic unlocked_q;
   logic window_open;
   logic code_wr;
   logic code_hit;
   logic reg_access;

   assign window_open = running && 32'(win_cnt_q) < WINDOW_CYC;
   assign code_wr = prog_ok && access_valid_i && access_write_i && access_addr_i == `SPL_UNLOCK_ADDR;
   assign code_hit = code_wr && access_data_i == `SPL_UNLOCK_CODE && window_open && !perm_q;
   assign reg_access = prog_ok && access_valid_i && !code_wr;

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         win_cnt_q <= 18'h00000;
         perm_q <= 1'b0;
         unlocked_q <= 1'b0;
         access_granted_o <= 1'b0;
         access_refused_o <= 1'b0;
         default_lock_o <= 1'b1;
         permanent_lock_o <= 1'b0;
      end
      else
      begin
         if (state_q == SPL_RESET)
            win_cnt_q <= 18'h00000;
         else if (window_open)
            win_cnt_q <= win_cnt_q + 18'h00001;
         // or-ed in at each release so the bit can never clear until the supply is removed
         if (state_q == SPL_RELEASE && state_d == SPL_RUN)
            perm_q <= perm_q | permanent_lock_bit_i;
         // dropping below the lower threshold is a power cycle too, so the lock comes back
         if (state_q == SPL_RESET)
            unlocked_q <= 1'b0;
         else if (code_hit)
            unlocked_q <= 1'b1;
         access_granted_o <= reg_access && unlocked_q && !perm_q;
         access_refused_o <= reg_access && (!unlocked_q || perm_q);
         default_lock_o <= !(unlocked_q || code_hit);
         permanent_lock_o <= perm_q;
      end
   end

   chk_lock_grant: assert property (@(posedge clock_i) disable iff (!rstn_i)
      access_granted_o |-> !perm_q && $past(unlocked_q))
      else $error("access granted while locked");
   chk_late_code: assert property (@(posedge clock_i) disable iff (!rstn_i)
      code_wr && !window_open |=> $stable(unlocked_q))
      else $error("late code changed lock");
   chk_wrong_code: assert property (@(posedge clock_i) disable iff (!rstn_i)
      code_wr && access_data_i != `SPL_UNLOCK_CODE && !unlocked_q |=> default_lock_o)
      else $error("wrong code released lock");
   chk_perm_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
      permanent_lock_o |=> permanent_lock_o)
      else $error("permanent lock cleared");
   chk_perm_refuse: assert property (@(posedge clock_i) disable iff (!rstn_i)
      reg_access && perm_q |=> access_refused_o && !access_granted_o)
      else $error("access under permanent lock");
   chk_perm_code: assert property (@(posedge clock_i) disable iff (!rstn_i)
      perm_q && code_wr |=> $stable(unlocked_q))
      else $error("code honoured under permanent lock");
   chk_no_access: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !prog_ok |=> !access_granted_o && !access_refused_o)
      else $error("access outside over-voltage programming");
   chk_code_silent: assert property (@(posedge clock_i) disable iff (!rstn_i)
      code_wr |=> !access_granted_o && !access_refused_o)
      else $error("code write answered");
   chk_unlock_code: assert property (@(posedge clock_i) disable iff (!rstn_i)
      code_hit |=> unlocked_q && !default_lock_o)
      else $error("good code did not unlock");
   chk_refuse_locked: assert property (@(posedge clock_i) disable iff (!rstn_i)
      reg_access && !unlocked_q |=> access_refused_o)
      else $error("locked access not refused");
   chk_boot_locked: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_RELEASE |=> default_lock_o)
      else $error("lock open during release");
   chk_lock_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_q == SPL_RESET |-> ##2 default_lock_o)
      else $error("lock not restored by reset");
   chk_window_shut: assert property (@(posedge clock_i) disable iff (!rstn_i)
      running && !window_open |=> $stable(win_cnt_q))
      else $error("window counter moved after close");
endmodule : spl_top
`default_nettype wire

// [spl_regs.svh]
// constants of the supply-state and access-lock block: offsets, codes, times
// assumes a 10 MHz core clock; included by the package and the design file
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH
`define SPL_UNLOCK_ADDR 6'h36
`define SPL_CLK_NS 100
`define SPL_UNLOCK_WINDOW_MS 10
`define SPL_UNLOCK_WINDOW_CYC ((`SPL_UNLOCK_WINDOW_MS * 1000000) / `SPL_CLK_NS)
`define SPL_RELEASE_TIME_US 64
`define SPL_RELEASE_CYC ((`SPL_RELEASE_TIME_US * 1000) / `SPL_CLK_NS)
`define SPL_POWER_ON_TIME_US 100
`define SPL_POWER_ON_CYC ((`SPL_POWER_ON_TIME_US * 1000) / `SPL_CLK_NS)
`define SPL_SETTLE_TIME_US 500
`define SPL_SETTLE_CYC ((`SPL_SETTLE_TIME_US * 1000) / `SPL_CLK_NS)
`define SPL_UNLOCK_CODE 32'h5A5A_C3C3
`endif

// [spl_pkg.sv]
// types of the supply-state and access-lock block
// assumes spl_regs.svh alongside
`include "spl_regs.svh"
package spl_pkg;
   typedef enum logic [4:0] {
      SPL_RESET = 5'h01,
      SPL_RELEASE = 5'h02,
      SPL_RUN = 5'h04,
      SPL_OVER = 5'h08,
      SPL_UNDER = 5'h10
   } spl_state_t;
   typedef enum logic [1:0] {
      SPL_PIN_ANALOG = 2'h0,
      SPL_PIN_HIZ = 2'h1,
      SPL_PIN_SERIAL = 2'h2,
      SPL_PIN_LOW = 2'h3
   } spl_pin_src_t;
endpackage : spl_pkg

// [spl_ctrl_model.sv]
// far-side programming controller sharing the sensor output pin
// assumes the device reports program mode and its own pin enable each cycle
`timescale 1ns/1ps
`default_nettype none
module spl_ctrl_model
(
   input wire logic clock_i,
   input wire logic program_mode_i,
   input wire logic dev_oe_i,
   input wire logic dev_pin_i,
   output logic wire_level_o,
   output logic clash_o
);
   logic ctrl_low_q;
   //////////////////////////////////////////////////////////////////////
   // pulls the line low once program mode is seen so stray edges are not data
   always_ff @(posedge clock_i)
   begin
      ctrl_low_q <= program_mode_i;
   end
   // load resistor to ground: a released line reads 0
   assign wire_level_o = dev_oe_i ? dev_pin_i : 1'b0;
   assign clash_o = dev_oe_i & ctrl_low_q;
endmodule : spl_ctrl_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the supply-state and access-lock block
// assumes spl_pkg, spl_regs.svh and the controller model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "spl_regs.svh"
module tb_top;
   import spl_pkg::*;
   logic clock_i = 0, rstn_i = 0, above_upper_reset_threshold_i = 0, below_lower_reset_threshold_i = 0;
   logic above_over_voltage_enable_level_i = 0, below_over_voltage_disable_level_i = 1;
   logic below_under_voltage_enable_level_i = 0, above_under_voltage_disable_level_i = 1;
   logic under_voltage_variant_i = 0, supply_above_program_enable_high_level_i = 0, program_enable_pin_i = 0;
   logic serial_drive_select_i = 0, output_disable_i = 0, serial_tx_bit_i = 0, access_valid_i = 0;
   logic access_write_i = 0, permanent_lock_bit_i = 0, g, r, wl, clash;
   logic [5:0] access_addr_i = 6'h00;
   logic [31:0] access_data_i = 32'h0;
   logic [1:0] pin_source_o;
   logic sensor_output_pin_oe_o, sensor_output_pin_o, program_mode_o, compensated_valid_o;
   logic access_granted_o, access_refused_o, default_lock_o, permanent_lock_o;
   int err_total = 0, comparisons = 0;
   always #50 clock_i = ~clock_i;
   spl_top dut (.clock_i, .rstn_i, .above_upper_reset_threshold_i, .below_lower_reset_threshold_i,
      .above_over_voltage_enable_level_i, .below_over_voltage_disable_level_i,
      .below_under_voltage_enable_level_i, .above_under_voltage_disable_level_i, .under_voltage_variant_i,
      .supply_above_program_enable_high_level_i, .program_enable_pin_i, .serial_drive_select_i,
      .output_disable_i, .serial_tx_bit_i, .access_valid_i, .access_write_i, .access_addr_i, .access_data_i,
      .permanent_lock_bit_i, .pin_source_o, .sensor_output_pin_oe_o, .sensor_output_pin_o, .program_mode_o,
      .compensated_valid_o, .access_granted_o, .access_refused_o, .default_lock_o, .permanent_lock_o);
   spl_ctrl_model ctrl (.clock_i, .program_mode_i(program_mode_o), .dev_oe_i(sensor_output_pin_oe_o),
      .dev_pin_i(sensor_output_pin_o), .wire_level_o(wl), .clash_o(clash));
   //////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      comparisons++;
      if (v !== e)
      begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", n, e, v);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc
   // one access; the pulse may land on the sampling edge or on the edge after it
   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clock_i);
      access_valid_i <= 1'b1;
      access_write_i <= w;
      access_addr_i <= a;
      access_data_i <= d;
      @(posedge clock_i);
      access_valid_i <= 1'b0;
      #1;
      g = access_granted_o;
      r = access_refused_o;
      cyc(1);
      g = g | access_granted_o;
      r = r | access_refused_o;
   endtask : acc
   task automatic boot(input logic lockbit);
      @(posedge clock_i);
      rstn_i <= 1'b0;
      above_upper_reset_threshold_i <= 1'b0;
      below_lower_reset_threshold_i <= 1'b0;
      permanent_lock_bit_i <= lockbit;
      cyc(16);
      chk("src", 1, pin_source_o);
      @(posedge clock_i);
      rstn_i <= 1'b1;
      above_upper_reset_threshold_i <= 1'b1;
      cyc(600);
      chk("src", 1, pin_source_o);
      for (int i = 0; i < 100 && pin_source_o !== 2'h0; i++)
         cyc(1);
      chk("src", 0, pin_source_o);
      chk("lock", 1, default_lock_o);
   endtask : boot
   task automatic prog(input logic on);
      @(posedge clock_i);
      above_over_voltage_enable_level_i <= on;
      below_over_voltage_disable_level_i <= !on;
      supply_above_program_enable_high_level_i <= on;
      cyc(3);
   endtask : prog
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      #(30000 * 100);
      err_total++;
      conclude();
   end
   initial
   begin
      boot(0);
      chk("comp", 0, compensated_valid_o);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock_i);
         serial_drive_select_i <= i[1];
         output_disable_i <= i[0];
         serial_tx_bit_i <= i[0];
         cyc(3);
         chk("src", i[1] ? 2 : i[0], pin_source_o);
         if (i[1])
            chk("wire", i[0], wl);
      end
      @(posedge clock_i);
      serial_drive_select_i <= 1'b0;
      output_disable_i <= 1'b0;
      above_over_voltage_enable_level_i <= 1'b1;
      below_over_voltage_disable_level_i <= 1'b0;
      cyc(3);
      chk("src", 1, pin_source_o);
      @(posedge clock_i);
      above_over_voltage_enable_level_i <= 1'b0;
      cyc(3);
      chk("src", 1, pin_source_o);
      prog(0);
      chk("src", 0, pin_source_o);
      $display("test supply states done");
      prog(1);
      chk("prog", 1, program_mode_o);
      chk("oe", 0, sensor_output_pin_oe_o);
      chk("clash", 0, clash);
      acc(0, 6'h10, 32'h0);
      chk("refused", 1, r);
      acc(1, 6'h36, 32'h1234_5678);
      chk("lock", 1, default_lock_o);
      acc(1, `SPL_UNLOCK_ADDR, `SPL_UNLOCK_CODE);
      chk("lock", 0, default_lock_o);
      acc(0, 6'h10, 32'h0);
      chk("granted", 1, g);
      prog(0);
      acc(0, 6'h10, 32'h0);
      chk("pulse", 0, g | r);
      $display("test unlock done");
      @(posedge clock_i);
      program_enable_pin_i <= 1'b1;
      cyc(3);
      chk("prog", 0, program_mode_o);
      @(posedge clock_i);
      under_voltage_variant_i <= 1'b1;
      cyc(3);
      chk("prog", 1, program_mode_o);
      @(posedge clock_i);
      program_enable_pin_i <= 1'b0;
      below_under_voltage_enable_level_i <= 1'b1;
      above_under_voltage_disable_level_i <= 1'b0;
      cyc(3);
      chk("src", 3, pin_source_o);
      chk("pin", 0, wl);
      @(posedge clock_i);
      below_under_voltage_enable_level_i <= 1'b0;
      above_under_voltage_disable_level_i <= 1'b1;
      cyc(3);
      chk("src", 0, pin_source_o);
      for (int i = 0; i < 7000 && compensated_valid_o !== 1'b1; i++)
         cyc(1);
      chk("comp", 1, compensated_valid_o);
      $display("test variant done");
      boot(1);
      chk("lock", 1, default_lock_o);
      chk("plock", 1, permanent_lock_o);
      prog(1);
      acc(1, `SPL_UNLOCK_ADDR, `SPL_UNLOCK_CODE);
      chk("lock", 1, default_lock_o);
      acc(1, 6'h10, 32'h0);
      chk("refused", 1, r);
      prog(0);
      @(posedge clock_i);
      above_upper_reset_threshold_i <= 1'b0;
      below_lower_reset_threshold_i <= 1'b1;
      cyc(3);
      chk("src", 1, pin_source_o);
      chk("oe", 0, sensor_output_pin_oe_o);
      $display("test power cycle done");
      conclude();
   end
endmodule : tb_top
`default_nettype wire
